// file: hdl/protect_pkg.sv
// Contract
// - Detector zero high side/comp five; one low/comp three.
// - Control bits 2,3 invert comparator five, three.
// - Width runs drive rise to comparator rise.
// - Width below threshold sets small-phase flag.
// - Zero width sets no-phase flag.
// - Small or no-phase setting sets detector flag.
// - Comparators one, two, four may force off.
// - Status bits 4-6 mirror comparator flags.
// - Mirror flags set on either edge; cleared by write.
// - Writing F7h clears only detector flag.
// - Status bit 2 shows drive forced off.
// - Drive-off cause sets flag and latch; latch forces drive off.
// - Clearing latch restarts phase detection.
// - Restart waits coded number of drive periods.
// - Control bit 0 enables both phase detectors.
// - Group enable bit 5 gates CPU request.
// - Writes FBh, FDh, FEh clear their flags.
// - Enable bit 2 lets phase faults force off.
// - Enable bits 1, 0 gate the two interrupts.
package protect_pkg;

	// ----------------------------------------
	// Register indices, byte address is four times
	// ----------------------------------------
	localparam logic [9:0] IDX_CONTROL   = 10'h09A;
	localparam logic [9:0] IDX_STATUS    = 10'h09B;
	localparam logic [9:0] IDX_THRESHOLD = 10'h09C;
	localparam logic [9:0] IDX_FORCE_EN  = 10'h09D;
	localparam logic [9:0] IDX_DRIVE_CTL = 10'h09E;
	localparam logic [9:0] IDX_IRQ_GROUP = 10'h0A9;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTL_ENABLE    = 0;
	localparam int CTL_POL_ZERO  = 2;
	localparam int CTL_POL_ONE   = 3;
	localparam int CTL_DELAY_LSB = 4;
	localparam int ST_SMALL      = 0;
	localparam int ST_NONE       = 1;
	localparam int ST_OFF        = 2;
	localparam int ST_DET_IRQ    = 3;
	localparam int ST_CMP_ONE    = 4;
	localparam int ST_CMP_TWO    = 5;
	localparam int ST_CMP_FOUR   = 6;
	localparam int EN_DET_IRQ    = 0;
	localparam int EN_OFF_IRQ    = 1;
	localparam int EN_PHASE_OFF  = 2;
	localparam int EN_CMP_ONE    = 3;
	localparam int EN_CMP_TWO    = 4;
	localparam int EN_CMP_FOUR   = 5;
	localparam int GROUP_IRQ_EN  = 5;
	localparam int CMP_ONE       = 0;
	localparam int CMP_TWO       = 1;
	localparam int CMP_THREE     = 2;
	localparam int CMP_FOUR      = 3;
	localparam int CMP_FIVE      = 4;
	localparam int CMP_COUNT     = 5;

	// ----------------------------------------
	// Reset values and masks
	// ----------------------------------------
	localparam logic [7:0] RESET_BYTE    = 8'h00;
	localparam logic [7:0] CONTROL_MASK  = 8'h7D;
	localparam logic [7:0] FORCE_EN_MASK = 8'h3F;
	localparam logic [7:0] WIDTH_ZERO    = 8'h00;
	localparam logic [7:0] WIDTH_ONE     = 8'h01;
	localparam logic [7:0] WIDTH_MAX     = 8'hFF;

	// Restart sequencing of the detectors
	typedef enum logic [1:0] {
		DET_OFF  = 2'b00,
		DET_WAIT = 2'b01,
		DET_RUN  = 2'b10
	} det_state_t;

endpackage

// file: hdl/phase_link_if.sv
`timescale 1ns/10ps
// One detector's inputs and fault pulses
interface phase_link_if;
	logic       active;
	logic       pwm_rise;
	logic       cmp_rise;
	logic [7:0] threshold;
	logic       small_hit;
	logic       none_hit;
	modport det (input active, pwm_rise, cmp_rise, threshold, output small_hit, none_hit);
	modport ctl (output active, pwm_rise, cmp_rise, threshold, input small_hit, none_hit);
endinterface

// file: hdl/input_sync.sv
`timescale 1ns/10ps
module input_sync
	import protect_pkg::*;
#(
	parameter int N = CMP_COUNT
)(
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic [N-1:0] async_in,
	output logic      [N-1:0] level_q
);
	// ----------------------------------------
	// Three stages, change taken when last two agree
	// ----------------------------------------
	for (genvar i = 0; i < N; i++)
	begin : g_bit
		logic s1_q;
		logic s2_q;
		logic s3_q;
		logic lvl_q;
		always_ff @(posedge clock or negedge rst_n)
		begin
			if (!rst_n)
			begin
				s1_q  <= 1'b0;
				s2_q  <= 1'b0;
				s3_q  <= 1'b0;
				lvl_q <= 1'b0;
			end
			else
			begin
				s1_q <= async_in[i];
				s2_q <= s1_q;
				s3_q <= s2_q;
				if (s2_q == s3_q)
					lvl_q <= s3_q;
			end
		end
		assign level_q[i] = lvl_q;
	end
endmodule

// file: hdl/phase_detector.sv
`timescale 1ns/10ps
module phase_detector
	import protect_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	phase_link_if.det link
);
	logic [7:0] count_q;
	logic [7:0] count_d;
	logic       armed_q;
	logic       armed_d;
	wire  [7:0] width;
	wire        hit;

	// ----------------------------------------
	// Measure and compare
	// ----------------------------------------
	// Width is clocks since drive rise, zero on the same edge
	assign width = link.pwm_rise ? WIDTH_ZERO : count_q;
	assign hit   = link.active & link.cmp_rise & (armed_q | link.pwm_rise);
	assign link.none_hit  = hit & (width == WIDTH_ZERO);
	assign link.small_hit = hit & (width < link.threshold);

	// Counter saturates so a late edge never wraps to a small width
	always_comb
	begin
		count_d = count_q;
		armed_d = armed_q;
		if (!link.active)
		begin
			armed_d = 1'b0;
			count_d = WIDTH_ZERO;
		end
		else if (link.pwm_rise)
		begin
			armed_d = !link.cmp_rise;
			count_d = WIDTH_ONE;
		end
		else if (hit)
			armed_d = 1'b0;
		else if (armed_q && count_q != WIDTH_MAX)
			count_d = count_q + WIDTH_ONE;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_q <= WIDTH_ZERO;
			armed_q <= 1'b0;
		end
		else
		begin
			count_q <= count_d;
			armed_q <= armed_d;
		end
	end
endmodule

// file: hdl/phase_protect_detector.sv
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
module phase_protect_detector
	import protect_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        high_side_drive,
	input  wire logic        low_side_drive,
	input  wire logic        comparator_one,
	input  wire logic        comparator_two,
	input  wire logic        comparator_three,
	input  wire logic        comparator_four,
	input  wire logic        comparator_five,
	output logic             drive_force_off,
	output logic             drive_clear_latch,
	output logic             cpu_irq_request
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic       rst_a_q;
	logic       rst_n_q;
	logic [7:0] ctrl_q;
	logic [7:0] thr_q;
	logic [7:0] fen_q;
	logic [7:0] group_q;
	logic [6:0] status_q;
	logic [6:0] status_d;
	logic       latch_q;
	logic       latch_d;
	logic [2:0] wait_q;
	logic [2:0] wait_d;
	logic [31:0] prdata_q;
	logic [4:0] cmp_lvl;
	logic [4:0] cmp_prev_q;
	logic [1:0] drive_prev_q;
	logic [1:0] sel_prev_q;
	det_state_t state_q;
	det_state_t state_d;

	phase_link_if link0 ();
	phase_link_if link1 ();

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	// Two-stage release of the asynchronous reset
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_a_q <= 1'b0;
			rst_n_q <= 1'b0;
		end
		else
		begin
			rst_a_q <= 1'b1;
			rst_n_q <= rst_a_q;
		end
	end

	// ----------------------------------------
	// Comparator synchronisers and edges
	// ----------------------------------------
	input_sync #(.N(CMP_COUNT)) u_sync (
		.clock    (clock),
		.rst_n    (rst_n_q),
		.async_in ({comparator_five, comparator_four, comparator_three,
		            comparator_two, comparator_one}),
		.level_q  (cmp_lvl)
	);

	// Selected comparator inputs, true or inverted
	wire sel_zero = cmp_lvl[CMP_FIVE] ^ ctrl_q[CTL_POL_ZERO];
	wire sel_one  = cmp_lvl[CMP_THREE] ^ ctrl_q[CTL_POL_ONE];
	wire [4:0] cmp_ev = cmp_lvl ^ cmp_prev_q;
	wire hs_rise = high_side_drive & !drive_prev_q[0];
	wire ls_rise = low_side_drive & !drive_prev_q[1];

	always_ff @(posedge clock or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			cmp_prev_q   <= 5'h00;
			drive_prev_q <= 2'h0;
			sel_prev_q   <= 2'h0;
		end
		else
		begin
			cmp_prev_q   <= cmp_lvl;
			drive_prev_q <= {low_side_drive, high_side_drive};
			sel_prev_q   <= {sel_one, sel_zero};
		end
	end

	// ----------------------------------------
	// Phase detectors
	// ----------------------------------------
	wire det_run = (state_q == DET_RUN);
	assign link0.active    = det_run;
	assign link0.pwm_rise  = hs_rise;
	assign link0.cmp_rise  = sel_zero & !sel_prev_q[0];
	assign link0.threshold = thr_q;
	assign link1.active    = det_run;
	assign link1.pwm_rise  = ls_rise;
	assign link1.cmp_rise  = sel_one & !sel_prev_q[1];
	assign link1.threshold = thr_q;

	phase_detector u_det0 (
		.clock (clock),
		.rst_n (rst_n_q),
		.link  (link0)
	);

	phase_detector u_det1 (
		.clock (clock),
		.rst_n (rst_n_q),
		.link  (link1)
	);

	wire phase_small = link0.small_hit | link1.small_hit;
	wire phase_none  = link0.none_hit | link1.none_hit;
	wire phase_fault = phase_small | phase_none;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire [9:0] idx     = paddr[11:2];
	wire       aligned = (paddr[1:0] == 2'b00);
	wire sel_ctl   = aligned & (idx == IDX_CONTROL);
	wire sel_sta   = aligned & (idx == IDX_STATUS);
	wire sel_thr   = aligned & (idx == IDX_THRESHOLD);
	wire sel_fen   = aligned & (idx == IDX_FORCE_EN);
	wire sel_drv   = aligned & (idx == IDX_DRIVE_CTL);
	wire sel_grp   = aligned & (idx == IDX_IRQ_GROUP);
	wire mapped    = sel_ctl | sel_sta | sel_thr | sel_fen | sel_drv | sel_grp;
	wire setup     = psel & !penable;
	wire wr        = psel & penable & pwrite & mapped;
	wire [7:0] wbyte = pwdata[7:0];
	wire [7:0] rd_val = sel_ctl ? ctrl_q :
	                    sel_sta ? {1'b0, status_q} :
	                    sel_thr ? thr_q :
	                    sel_fen ? fen_q :
	                    sel_drv ? {7'h00, latch_q} :
	                    sel_grp ? group_q : RESET_BYTE;

	// Zero-wait slave, error on an unmapped word
	assign pready  = 1'b1;
	assign pslverr = psel & penable & !mapped;
	assign prdata  = prdata_q;

	// Read data captured in the setup cycle
	always_ff @(posedge clock or negedge rst_n_q)
	begin
		if (!rst_n_q)
			prdata_q <= 32'h0000_0000;
		else if (setup)
			prdata_q <= {24'h00_0000, rd_val};
	end

	// ----------------------------------------
	// Plain read/write registers
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			ctrl_q  <= RESET_BYTE;
			thr_q   <= RESET_BYTE;
			fen_q   <= RESET_BYTE;
			group_q <= RESET_BYTE;
		end
		else
		begin
			if (wr && sel_ctl)
				ctrl_q <= wbyte & CONTROL_MASK;
			if (wr && sel_thr)
				thr_q <= wbyte;
			if (wr && sel_fen)
				fen_q <= wbyte & FORCE_EN_MASK;
			if (wr && sel_grp)
				group_q <= wbyte;
		end
	end

	// ----------------------------------------
	// Status flags and forced-off latch
	// ----------------------------------------
	// Comparator and phase causes of the forced-off state
	wire off_set = (phase_fault & fen_q[EN_PHASE_OFF])
	             | (cmp_ev[CMP_ONE] & fen_q[EN_CMP_ONE])
	             | (cmp_ev[CMP_TWO] & fen_q[EN_CMP_TWO])
	             | (cmp_ev[CMP_FOUR] & fen_q[EN_CMP_FOUR]);
	wire [6:0] set_v = {cmp_ev[CMP_FOUR], cmp_ev[CMP_TWO], cmp_ev[CMP_ONE],
	                    phase_fault, off_set, phase_none, phase_small};
	wire [6:0] clr_v = (wr && sel_sta) ? ~wbyte[6:0] : 7'h00;

	// Hardware set wins over a clearing write in the same cycle
	assign status_d = (status_q & ~clr_v) | set_v;
	assign latch_d  = off_set ? 1'b1 :
	                  (wr && sel_drv) ? wbyte[0] : latch_q;

	always_ff @(posedge clock or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			status_q <= 7'h00;
			latch_q  <= 1'b0;
		end
		else
		begin
			status_q <= status_d;
			latch_q  <= latch_d;
		end
	end

	assign drive_force_off   = latch_q;
	assign drive_clear_latch = latch_q;
	assign cpu_irq_request   = group_q[GROUP_IRQ_EN] &
	                           ((status_q[ST_DET_IRQ] & fen_q[EN_DET_IRQ]) |
	                            (status_q[ST_OFF] & fen_q[EN_OFF_IRQ]));

	// ----------------------------------------
	// Restart sequencing
	// ----------------------------------------
	wire [2:0] delay_code = ctrl_q[CTL_DELAY_LSB +: 3];
	wire       may_run    = ctrl_q[CTL_ENABLE] & !latch_q;

	// Off while latched, then wait coded drive periods
	always_comb
	begin
		state_d = state_q;
		wait_d  = wait_q;
		unique case (state_q)
			DET_OFF:
			begin
				if (may_run)
				begin
					wait_d  = delay_code;
					state_d = (delay_code == 3'h0) ? DET_RUN : DET_WAIT;
				end
			end
			DET_WAIT:
			begin
				if (!may_run)
					state_d = DET_OFF;
				else if (hs_rise)
				begin
					wait_d  = wait_q - 3'h1;
					state_d = (wait_q == 3'h1) ? DET_RUN : DET_WAIT;
				end
			end
			DET_RUN:
			begin
				if (!may_run)
					state_d = DET_OFF;
			end
			default:
				state_d = DET_OFF;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			state_q <= DET_OFF;
			wait_q  <= 3'h0;
		end
		else
		begin
			state_q <= state_d;
			wait_q  <= wait_d;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n_q);

	a_small_flags: assert property (phase_small |=> status_q[ST_SMALL] && status_q[ST_DET_IRQ])
		else $error("small phase did not set flags");
	a_none_flag: assert property (phase_none |=> status_q[ST_NONE] && status_q[ST_DET_IRQ])
		else $error("no phase did not set flag");
	a_mirror_edge: assert property ($changed(cmp_lvl[CMP_FOUR]) |=> status_q[ST_CMP_FOUR])
		else $error("comparator four edge lost");
	a_irq_clear_only: assert property (wr && sel_sta && wbyte == 8'hF7 && set_v == 7'h00
		|=> status_q == ($past(status_q) & 7'h77))
		else $error("detector flag clear touched others");
	a_phase_force: assert property (phase_fault && fen_q[EN_PHASE_OFF] |=> drive_force_off && status_q[ST_OFF])
		else $error("phase fault did not force off");
	a_latch_hold: assert property (latch_q && !(wr && sel_drv && !wbyte[0]) |=> latch_q)
		else $error("forced-off latch dropped");
	a_no_detect_idle: assert property (!det_run |-> !phase_fault)
		else $error("fault while detection idle");
	a_restart_now: assert property (state_q == DET_OFF && may_run && delay_code == 3'h0 |=> det_run)
		else $error("zero delay restart late");
	a_restart_wait: assert property ($fell(latch_q) && ctrl_q[CTL_ENABLE] && delay_code == 3'h6
		|-> !det_run [*8])
		else $error("restart did not wait");
	a_irq_gate: assert property (!group_q[GROUP_IRQ_EN] |-> !cpu_irq_request)
		else $error("request not gated");

	c_small_seen: cover property (phase_small);
	c_force_off: cover property ($rose(latch_q));
	c_restart: cover property (state_q == DET_WAIT ##[1:200] det_run);
	c_clear_race: cover property (wr && sel_sta && |(set_v & ~wbyte[6:0]));
endmodule

// file: tb/drive_partner.sv
`timescale 1ns/10ps
module drive_partner (
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic       run,
	input  wire logic       drive_force_off,
	input  wire logic [7:0] delay_five,
	input  wire logic [7:0] delay_three,
	output logic            high_side_drive,
	output logic            low_side_drive,
	output logic            comparator_five,
	output logic            comparator_three
);
	logic [7:0] phase_q;
	logic       run_q;
	logic       allow;

	// Period of 100 clocks; run is taken only at a period boundary
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			phase_q <= 8'h00;
			run_q   <= 1'b0;
		end
		else
		begin
			phase_q <= (phase_q == 8'h63) ? 8'h00 : phase_q + 8'h01;
			if (phase_q == 8'h63)
				run_q <= run;
		end
	end

	// Bridge stays dark while the block holds it off
	assign allow            = run_q && !drive_force_off;
	// High side first, dead time, then low side
	assign high_side_drive  = allow && (phase_q < 8'h28);
	assign low_side_drive   = allow && (phase_q >= 8'h32) && (phase_q < 8'h5A);
	// Each comparator answers its own drive after its delay
	// A late five answer lands on the next high-side rise: zero width
	assign comparator_five  = allow && (phase_q >= delay_five)
	                          && (phase_q < delay_five + 8'h41);
	assign comparator_three = allow && (phase_q >= 8'h32 + delay_three) && (phase_q < 8'h5F);
endmodule

// file: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
	import protect_pkg::*;
	logic        clock, reset_n, psel, penable, pwrite, run;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic        pready, pslverr, err_seen, irq, force_off, latch_out;
	logic        high_side_drive, low_side_drive, comparator_five, comparator_three;
	logic [2:0]  cmp_pin;
	logic [7:0]  d5, d3;
	int          bad_count, n_tests;
	logic [9:0]  regs [6] = '{IDX_CONTROL, IDX_STATUS, IDX_THRESHOLD, IDX_FORCE_EN,
		IDX_DRIVE_CTL, IDX_IRQ_GROUP};
	logic [7:0]  clr_tab [3] = '{8'hEF, 8'hDF, 8'hBF};
	logic [7:0]  ctl_tab [6] = '{8'h01, 8'h05, 8'h01, 8'h09, 8'h00, 8'h01};
	logic [7:0]  d5_tab  [6] = '{8'h05, 8'h05, 8'h28, 8'h28, 8'h05, 8'h60};
	logic [7:0]  d3_tab  [6] = '{8'h28, 8'h28, 8'h05, 8'h05, 8'h28, 8'h28};
	logic [7:0]  exp_tab [6] = '{8'h09, 8'h00, 8'h09, 8'h00, 8'h00, 8'h0B};

	// ----------------------------------------
	// Design, far side and clock
	// ----------------------------------------
	phase_protect_detector phase_protect_detector_i (.clock(clock), .reset_n(reset_n),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
		.comparator_one(cmp_pin[0]), .comparator_two(cmp_pin[1]),
		.comparator_three(comparator_three), .comparator_four(cmp_pin[2]),
		.comparator_five(comparator_five), .drive_force_off(force_off),
		.drive_clear_latch(latch_out), .cpu_irq_request(irq));
	drive_partner drive_partner_i (.clock(clock), .reset_n(reset_n), .run(run),
		.drive_force_off(force_off), .delay_five(d5), .delay_three(d3),
		.high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
		.comparator_five(comparator_five), .comparator_three(comparator_three));

	// Free-running 100 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
			bad_count++;
		end
	endtask

	// One APB transfer, held until pready is seen high
	task automatic apb(input logic wr_en, input logic [9:0] idx, input logic [7:0] val);
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr_en;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h000000, val};
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		rdata    = prdata;
		err_seen = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [9:0] idx, input logic [7:0] val);
		apb(1'b1, idx, val);
	endtask

	task automatic rd_chk(input string what, input logic [9:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		check(what, rdata, {24'h000000, exp});
	endtask

	task automatic check_out(input string what, input logic [1:0] exp);
		@(negedge clock);
		check(what, {30'h0, force_off, latch_out}, {30'h0, exp});
	endtask

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Watchdog against a hang
	initial
	begin
		#200000;
		bad_count++;
		end_of_test();
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		{psel, penable, pwrite, run, cmp_pin, paddr, pwdata} = '0;
		{d5, d3} = {8'h05, 8'h28};
		reset_n = 1'b0;
		tick(10);
		reset_n <= 1'b1;
		tick(3);
		foreach (regs[i]) rd_chk("reset value", regs[i], 8'h00);
		apb(1'b0, 10'h000, 8'h00);
		check("unmapped error", {31'h0, err_seen}, 32'h1);
		check("ready high", {31'h0, pready}, 32'h1);
		wr(IDX_CONTROL, 8'hFF);
		rd_chk("control mask", IDX_CONTROL, 8'h7D);
		wr(IDX_FORCE_EN, 8'hFF);
		rd_chk("force enable mask", IDX_FORCE_EN, 8'h3F);
		wr(IDX_FORCE_EN, 8'h00);
		wr(IDX_CONTROL, 8'h00);
		// Mirror flags on both edges, cleared one at a time after the rise, all at once after the fall
		cmp_pin <= 3'b111;
		tick(8);
		rd_chk("mirror on rise", IDX_STATUS, 8'h70);
		for (int i = 0; i < 3; i++)
		begin
			wr(IDX_STATUS, clr_tab[i]);
			rd_chk("mirror clear", IDX_STATUS, 8'h70 & (8'hE0 << i));
		end
		cmp_pin <= 3'b000;
		tick(8);
		rd_chk("mirror on fall", IDX_STATUS, 8'h70);
		wr(IDX_STATUS, 8'h00);
		rd_chk("all cleared", IDX_STATUS, 8'h00);
		// Comparators one, two and four each forcing the bridge off
		for (int i = 0; i < 3; i++)
		begin
			wr(IDX_FORCE_EN, 8'h08 << i);
			cmp_pin[i] <= 1'b1;
			tick(30);
			check_out("comparator force off", 2'b11);
			rd_chk("off flag", IDX_STATUS, (8'h10 << i) | 8'h04);
			wr(IDX_FORCE_EN, 8'h00);
			wr(IDX_DRIVE_CTL, 8'h00);
			check_out("latch released", 2'b00);
			cmp_pin[i] <= 1'b0;
			tick(8);
			wr(IDX_STATUS, 8'hFB);
			rd_chk("off flag cleared", IDX_STATUS, 8'h10 << i);
			wr(IDX_STATUS, 8'h00);
		end
		// Phase width against threshold, polarity, pairing, enable
		wr(IDX_THRESHOLD, 8'h20);
		for (int i = 0; i < 6; i++)
		begin
			wr(IDX_CONTROL, ctl_tab[i] & 8'hFE);
			wr(IDX_CONTROL, ctl_tab[i]);
			d5 <= d5_tab[i];
			d3 <= d3_tab[i];
			run <= 1'b1;
			tick(300);
			rd_chk("phase flags", IDX_STATUS, exp_tab[i]);
			// Disable first, keep polarity so no false comparator edge
			wr(IDX_CONTROL, ctl_tab[i] & 8'hFE);
			run <= 1'b0;
			tick(200);
			if (exp_tab[i] != 8'h00)
			begin
				wr(IDX_STATUS, 8'hF7);
				rd_chk("detector flag cleared", IDX_STATUS, exp_tab[i] & 8'h03);
			end
			wr(IDX_STATUS, 8'hFE);
			rd_chk("small flag cleared", IDX_STATUS, exp_tab[i] & 8'h02);
			wr(IDX_STATUS, 8'hFD);
			rd_chk("no-phase flag cleared", IDX_STATUS, 8'h00);
		end
		// Phase fault forcing off, request gating, delayed restart
		wr(IDX_FORCE_EN, 8'h04);
		wr(IDX_IRQ_GROUP, 8'h20);
		wr(IDX_CONTROL, 8'h01);
		d5 <= 8'h05;
		run <= 1'b1;
		tick(300);
		check_out("phase force off", 2'b11);
		rd_chk("off status", IDX_STATUS, 8'h0D);
		for (int j = 0; j < 4; j++)
		begin
			wr(IDX_FORCE_EN, 8'h04 + 8'(j));
			if (j == 3)
				wr(IDX_IRQ_GROUP, 8'h00);
			@(negedge clock);
			check("cpu request", {31'h0, irq}, {31'h0, (j == 1 || j == 2)});
		end
		wr(IDX_CONTROL, 8'h61);
		wr(IDX_STATUS, 8'h00);
		wr(IDX_DRIVE_CTL, 8'h00);
		tick(400);
		check_out("restart waiting", 2'b00);
		tick(400);
		check_out("restart detecting", 2'b11);
		end_of_test();
	end
endmodule
